// ### src/abi_defs.svh
/*
  Constants of the address break and interrupt source front end: register offsets,
  field positions, reset values and vector numbers.
  Assumes inclusion by bare name from the design files; defines only.
*/
// Notes on behaviour
// - Prefetch match with enable sets match flag
// - Break exception handling clears match flag
// - Flag and enable together request break
// - Control bit 0 enables break, resets 0
// - Bits 6..1 read zero; flag read-only
// - Break registers reset to 00, kept in standby; hardware standby clears them here
// - Three bytes hold address bits 23..1
// - Low byte bit 0 reads zero, uncompared
// - Normal mode skips address bits 23..16
// - NMI highest priority, always accepted
// - Control bit picks NMI edge polarity
// - NMI uses vector 7
// - Pin interrupts use vectors 16..18
// - NMI and pin interrupts wake standby
// - Pin sampled regardless of direction
// - Flags set even when disabled
// - Low, falling, rising or both edges
// - Sense code 00 low,01 fall,10 rise,11 both
// - Per-pin enable and priority level
// - Software can clear status flags
// - Clear by zero only after reading one
// - Handling clears edge flag; level needs high pin
// - 32 peripheral sources plus break, each leveled; break is fixed at level 0 and peripherals never request the CPU
// - Transfer-controller starts ignore masking
`ifndef ABI_DEFS_SVH
`define ABI_DEFS_SVH
`define ABI_OFS_BRK_CTRL   12'h000
`define ABI_OFS_BRK_HIGH   12'h004
`define ABI_OFS_BRK_MID    12'h008
`define ABI_OFS_BRK_LOW    12'h00c
`define ABI_OFS_SYS_CTRL   12'h010
`define ABI_OFS_SENSE      12'h014
`define ABI_OFS_PIN_EN     12'h018
`define ABI_OFS_PIN_STAT   12'h01c
`define ABI_OFS_LEVEL      12'h020
`define ABI_OFS_PERI_LVL   12'h024
`define ABI_OFS_PENDING    12'h028
`define ABI_BIT_FLAG       7
`define ABI_BIT_BRK_EN     0
`define ABI_BIT_NMI_EDGE   0
`define ABI_BIT_NORMAL     1
`define ABI_RST_BYTE       8'h00
`define ABI_RST_WORD       32'h0000_0000
`define ABI_VEC_NONE       8'h00
`define ABI_VEC_NMI        8'h07
`define ABI_VEC_PIN0       8'h10
`define ABI_VEC_BRK        8'h1b
`define ABI_NPIN           3
`define ABI_NPERI          32
`endif

// ### src/abi_pkg.sv
/*
  Types of the interrupt source front end.
  Assumes abi_defs.svh constants; no logic.
*/
package abi_pkg;
  typedef enum logic [1:0] {
    abi_sense_low,
    abi_sense_fall,
    abi_sense_rise,
    abi_sense_both
  } abi_sense_e;
  typedef struct packed {
    logic        valid;
    logic        level;
    logic [7:0]  vector;
  } abi_req_s;
  typedef struct packed {
    logic        ack;
    logic [7:0]  vector;
  } abi_ack_s;
endpackage

// ### src/abi_sync.sv
/*
  Two-flop synchroniser for asynchronous pin levels.
  Assumes one clock domain; first stage feeds only the second.
*/
`timescale 1ns/1ps
module abi_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// ### src/abi_pin_det.sv
/*
  One external pin interrupt: sense decode and status flag.
  Assumes a synchronised active-low pin input.
*/
`timescale 1ns/1ps
`include "abi_defs.svh"
module abi_pin_det (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Pin and setup
  input  wire logic       pin_n,
  input  wire logic [1:0] sense,
  // Software clear and handling
  input  wire logic       sw_clr,
  input  wire logic       handled,
  // Status
  output logic            flag_ff
);
  logic prev_ff;
  logic hit;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) prev_ff <= 1'b1;
    else prev_ff <= pin_n;
  end
  always_comb begin
    case (abi_pkg::abi_sense_e'(sense))
      abi_pkg::abi_sense_low:  hit = ~pin_n;
      abi_pkg::abi_sense_fall: hit = prev_ff & ~pin_n;
      abi_pkg::abi_sense_rise: hit = ~prev_ff & pin_n;
      abi_pkg::abi_sense_both: hit = prev_ff ^ pin_n;
      default:                 hit = 1'b0;
    endcase
  end
  // Set wins over any clear in the same cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) flag_ff <= 1'b0;
    else if (hit) flag_ff <= 1'b1;
    else if (sw_clr) flag_ff <= 1'b0;
    else if (handled && (sense != 2'b00 || pin_n)) flag_ff <= 1'b0;
  end
endmodule

// ### src/abi_top.sv
/*
  Address break unit and external interrupt sources with an APB register slave.
  Assumes a CPU core that takes the request, answers with a one-cycle ack
  carrying the vector, and drives prefetch addresses on the same clock.
*/
`timescale 1ns/1ps
`include "abi_defs.svh"
module abi_top (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // CPU prefetch
  input  wire logic                     fetch_valid,
  input  wire logic [23:0]              fetch_addr,
  // Pins, asynchronous
  input  wire logic                     nmi_pin,
  input  wire logic [`ABI_NPIN-1:0]     irq_pin_n,
  // Peripheral sources, same clock
  input  wire logic [`ABI_NPERI-1:0]    peri_req,
  input  wire logic [`ABI_NPERI-1:0]    peri_dtc,
  // CPU side
  input  wire abi_pkg::abi_ack_s        cpu_ack,
  output abi_pkg::abi_req_s             cpu_req,
  output logic                          dtc_start,
  output logic                          wake,
  // Hardware standby
  input  wire logic                     hw_standby
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]              brk_ctrl_ff;
  logic [7:0]              brk_high_ff;
  logic [7:0]              brk_mid_ff;
  logic [7:0]              brk_low_ff;
  logic [7:0]              sys_ctrl_ff;
  logic [7:0]              sense_ff;
  logic [7:0]              pin_en_ff;
  logic [7:0]              level_ff;
  logic [31:0]             peri_lvl_ff;
  logic [`ABI_NPIN-1:0]    read_one_ff;
  logic [`ABI_NPIN-1:0]    pin_flag;
  logic [`ABI_NPIN-1:0]    pin_sync;
  logic [`ABI_NPIN-1:0]    pin_clr;
  logic [`ABI_NPIN-1:0]    pin_hdl;
  logic [`ABI_NPIN:0]      sync_q;
  logic                    nmi_sync;
  logic                    nmi_prev_ff;
  logic                    nmi_pend_ff;
  logic                    rst_all;
  logic                    wr;
  logic                    rd;
  logic [7:0]              wbyte;
  logic [31:0]             nxt_prdata;
  logic                    addr_hit;
  logic                    brk_req;

  // Hardware standby resets registers and flags like chip reset, but not the synchronisers, nmi_prev_ff or prdata; software standby keeps all
  assign rst_all = sys_rst | hw_standby;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign wbyte   = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign pready  = 1'b1;

  function automatic logic is_at(input logic [11:0] a, input logic [11:0] ofs);
    is_at = (a == ofs);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a <= `ABI_OFS_PENDING) && (a[1:0] == 2'b00);
  endfunction

  assign pslverr = psel & penable & ~is_mapped(paddr);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  // Pins idle high; inverted through the stages so reset shows idle, no false edge
  abi_sync #(.W(`ABI_NPIN + 1)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       (~{nmi_pin, irq_pin_n}),
    .q       (sync_q)
  );
  assign nmi_sync = ~sync_q[`ABI_NPIN];
  assign pin_sync = ~sync_q[`ABI_NPIN-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Address break
  always_ff @(posedge clock or posedge rst_all) begin
    if (rst_all) begin
      brk_high_ff <= `ABI_RST_BYTE;
      brk_mid_ff  <= `ABI_RST_BYTE;
      brk_low_ff  <= `ABI_RST_BYTE;
    end else if (wr && pstrb[0]) begin
      if (is_at(paddr, `ABI_OFS_BRK_HIGH)) brk_high_ff <= wbyte;
      if (is_at(paddr, `ABI_OFS_BRK_MID)) brk_mid_ff <= wbyte;
      if (is_at(paddr, `ABI_OFS_BRK_LOW)) brk_low_ff <= {wbyte[7:1], 1'b0};
    end
  end

  // Bit 0 never compared; normal mode drops the top byte
  assign addr_hit = (fetch_addr[15:1] == {brk_mid_ff, brk_low_ff[7:1]}) &&
                    (sys_ctrl_ff[`ABI_BIT_NORMAL] ||
                     fetch_addr[23:16] == brk_high_ff);

  always_ff @(posedge clock or posedge rst_all) begin
    if (rst_all) begin
      brk_ctrl_ff <= `ABI_RST_BYTE;
    end else begin
      if (wr && pstrb[0] && is_at(paddr, `ABI_OFS_BRK_CTRL))
        brk_ctrl_ff[`ABI_BIT_BRK_EN] <= wbyte[`ABI_BIT_BRK_EN];
      if (fetch_valid && addr_hit && brk_ctrl_ff[`ABI_BIT_BRK_EN])
        brk_ctrl_ff[`ABI_BIT_FLAG] <= 1'b1;
      else if (cpu_ack.ack && cpu_ack.vector == `ABI_VEC_BRK)
        brk_ctrl_ff[`ABI_BIT_FLAG] <= 1'b0;
    end
  end

  assign brk_req = brk_ctrl_ff[`ABI_BIT_FLAG] & brk_ctrl_ff[`ABI_BIT_BRK_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clock or posedge rst_all) begin
    if (rst_all) begin
      sys_ctrl_ff <= `ABI_RST_BYTE;
      sense_ff    <= `ABI_RST_BYTE;
      pin_en_ff   <= `ABI_RST_BYTE;
      level_ff    <= `ABI_RST_BYTE;
      peri_lvl_ff <= `ABI_RST_WORD;
    end else if (wr) begin
      if (pstrb[0] && is_at(paddr, `ABI_OFS_SYS_CTRL)) sys_ctrl_ff <= {6'h00, wbyte[1:0]};
      if (pstrb[0] && is_at(paddr, `ABI_OFS_SENSE)) sense_ff <= {2'b00, wbyte[5:0]};
      if (pstrb[0] && is_at(paddr, `ABI_OFS_PIN_EN)) pin_en_ff <= {5'h00, wbyte[2:0]};
      if (pstrb[0] && is_at(paddr, `ABI_OFS_LEVEL)) level_ff <= {5'h00, wbyte[2:0]};
      if (is_at(paddr, `ABI_OFS_PERI_LVL)) begin
        for (int b = 0; b < 4; b++) begin
          if (pstrb[b]) peri_lvl_ff[8*b +: 8] <= pwdata[8*b +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // NMI edge detection
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) nmi_prev_ff <= 1'b1;
    else nmi_prev_ff <= nmi_sync;
  end

  always_ff @(posedge clock or posedge rst_all) begin
    if (rst_all) nmi_pend_ff <= 1'b0;
    else if (sys_ctrl_ff[`ABI_BIT_NMI_EDGE] ? (nmi_sync & ~nmi_prev_ff)
                                             : (~nmi_sync & nmi_prev_ff))
      nmi_pend_ff <= 1'b1;
    else if (cpu_ack.ack && cpu_ack.vector == `ABI_VEC_NMI) nmi_pend_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin interrupts
  generate
    for (genvar i = 0; i < `ABI_NPIN; i++) begin : g_pin
      // Read-then-write-zero clearing avoids losing a flag set between
      always_ff @(posedge clock or posedge rst_all) begin
        if (rst_all) read_one_ff[i] <= 1'b0;
        else if (rd && is_at(paddr, `ABI_OFS_PIN_STAT) && pin_flag[i]) read_one_ff[i] <= 1'b1;
        else if (pin_clr[i]) read_one_ff[i] <= 1'b0;
      end
      assign pin_clr[i] = wr && pstrb[0] && is_at(paddr, `ABI_OFS_PIN_STAT) &&
                          !wbyte[i] && read_one_ff[i];
      assign pin_hdl[i] = cpu_ack.ack && (cpu_ack.vector == `ABI_VEC_PIN0 + 8'(i));
      abi_pin_det u_det (
        .clock   (clock),
        .sys_rst (rst_all),
        .pin_n   (pin_sync[i]),
        .sense   (sense_ff[2*i +: 2]),
        .sw_clr  (pin_clr[i]),
        .handled (pin_hdl[i]),
        .flag_ff (pin_flag[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Request priority: NMI, then by level, then lowest vector
  always_comb begin
    cpu_req = '0;
    if (nmi_pend_ff) begin
      cpu_req.valid  = 1'b1;
      cpu_req.level  = 1'b1;
      cpu_req.vector = `ABI_VEC_NMI;
    end else begin
      for (int l = 1; l >= 0; l--) begin
        for (int i = `ABI_NPIN - 1; i >= 0; i--) begin
          if (!cpu_req.valid || cpu_req.level == 1'(l)) begin
            if (pin_flag[i] && pin_en_ff[i] && level_ff[i] == 1'(l) &&
                !(cpu_req.valid && cpu_req.level == 1'(l) && cpu_req.vector < `ABI_VEC_PIN0 + 8'(i)))
            begin
              cpu_req.valid  = 1'b1;
              cpu_req.level  = 1'(l);
              cpu_req.vector = `ABI_VEC_PIN0 + 8'(i);
            end
          end
        end
        if (!cpu_req.valid && brk_req) begin
          cpu_req.valid  = 1'b1;
          cpu_req.level  = 1'b0;
          cpu_req.vector = `ABI_VEC_BRK;
        end
      end
    end
  end

  // Transfer-controller starts bypass CPU masking entirely
  assign dtc_start = |(peri_req & peri_dtc);
  assign wake      = nmi_pend_ff | (|(pin_flag & pin_en_ff[`ABI_NPIN-1:0]));

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `ABI_OFS_BRK_CTRL: nxt_prdata = {24'h0, brk_ctrl_ff[7], 6'h00, brk_ctrl_ff[0]};
      `ABI_OFS_BRK_HIGH: nxt_prdata = {24'h0, brk_high_ff};
      `ABI_OFS_BRK_MID:  nxt_prdata = {24'h0, brk_mid_ff};
      `ABI_OFS_BRK_LOW:  nxt_prdata = {24'h0, brk_low_ff};
      `ABI_OFS_SYS_CTRL: nxt_prdata = {24'h0, sys_ctrl_ff};
      `ABI_OFS_SENSE:    nxt_prdata = {24'h0, sense_ff};
      `ABI_OFS_PIN_EN:   nxt_prdata = {24'h0, pin_en_ff};
      `ABI_OFS_PIN_STAT: nxt_prdata = {29'h0, pin_flag};
      `ABI_OFS_LEVEL:    nxt_prdata = {24'h0, level_ff};
      `ABI_OFS_PERI_LVL: nxt_prdata = peri_lvl_ff;
      `ABI_OFS_PENDING:  nxt_prdata = {22'h0, cpu_req.valid, cpu_req.level, cpu_req.vector};
      default:           nxt_prdata = 32'h0000_0000;
    endcase
  end

  // Registered read data: valid from the setup edge into the access phase
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= nxt_prdata;
  end
endmodule

// ### verif/abi_properties.sv
/*
  Checker for abi_top: break, NMI, pin and transfer-start relations.
  Assumes only the top ports; shadows the few register bits it needs.
*/
`timescale 1ns/1ps
module abi_props (
  // Clock, reset, APB
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic              hw_standby,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  // Core side
  input wire logic              fetch_valid,
  input wire logic [23:0]       fetch_addr,
  input wire logic              nmi_pin,
  input wire logic [31:0]       peri_req,
  input wire logic [31:0]       peri_dtc,
  input wire abi_pkg::abi_ack_s cpu_ack,
  input wire abi_pkg::abi_req_s cpu_req,
  input wire logic              dtc_start,
  input wire logic              wake
);
  logic        en_ff, norm_ff, rise_ff, hit;
  logic [2:0]  pen_ff;
  logic [23:0] bar_ff;
  logic [7:0]  vec;
  assign vec = cpu_req.valid ? cpu_req.vector : 8'h00;
  // Bit 0 never compared
  assign hit = fetch_valid && en_ff && fetch_addr[15:1] == bar_ff[15:1] &&
               (norm_ff || fetch_addr[23:16] == bar_ff[23:16]);
  always_ff @(posedge clock or posedge sys_rst or posedge hw_standby) begin
    if (sys_rst || hw_standby) begin
      {en_ff, norm_ff, rise_ff, pen_ff, bar_ff} <= '0;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        12'h000: en_ff <= pwdata[0];
        12'h004: bar_ff[23:16] <= pwdata[7:0];
        12'h008: bar_ff[15:8] <= pwdata[7:0];
        12'h00c: bar_ff[7:0] <= pwdata[7:0];
        12'h010: {norm_ff, rise_ff} <= pwdata[1:0];
        12'h018: pen_ff <= pwdata[2:0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst || hw_standby);
  a_break_hit_req: assert property (hit |=> cpu_req.valid)
    else $error("break hit without request");
  a_break_needs_en: assert property (vec == 8'h1b |-> en_ff)
    else $error("break request while disabled");
  a_break_ack_clr: assert property (cpu_ack.ack && cpu_ack.vector == 8'h1b && !hit
    |=> vec != 8'h1b) else $error("break flag kept after handling");
  a_nmi_edge_req: assert property ((rise_ff ? $rose(nmi_pin) : $fell(nmi_pin))
    |-> ##[1:6] vec == 8'h07) else $error("nmi edge not requested");
  a_pin_vec_en: assert property (vec inside {8'h10, 8'h11, 8'h12} |-> pen_ff[vec[1:0]])
    else $error("pin request while disabled");
  a_dtc_bypass: assert property (dtc_start == (|(peri_req & peri_dtc)))
    else $error("transfer start mismatch");
  a_nmi_wakes: assert property (vec == 8'h07 |-> wake)
    else $error("nmi pending without wake");
  a_ctrl_reserved: assert property (psel && penable && !pwrite && paddr == 12'h000
    |-> prdata[7:0] == {1'b0, 6'h00, en_ff} || prdata[6:0] == {6'h00, en_ff})
    else $error("control read wrong");
  c_break: cover property (vec == 8'h1b);
  c_nmi: cover property (cpu_ack.ack && cpu_ack.vector == 8'h07);
  c_pin: cover property (vec == 8'h10 && wake);
endmodule
bind abi_top abi_props abi_props_inst (
  .clock(clock), .sys_rst(sys_rst), .hw_standby(hw_standby), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .nmi_pin(nmi_pin),
  .peri_req(peri_req), .peri_dtc(peri_dtc), .cpu_ack(cpu_ack), .cpu_req(cpu_req),
  .dtc_start(dtc_start), .wake(wake)
);

// ### verif/abi_cpu_model.sv
/*
  Core model: takes requests and answers with a one-cycle ack.
  Assumes cpu_req settles one cycle after each ack.
*/
`timescale 1ns/1ps
module abi_cpu_model (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Request, answer, knobs
  input  wire abi_pkg::abi_req_s cpu_req,
  output abi_pkg::abi_ack_s      cpu_ack,
  input  wire logic              mask,
  input  wire logic [1:0]        dly
);
  logic [1:0] cnt_ff;
  logic       take;
  assign take = cpu_req.valid && (!mask || cpu_req.vector == 8'h07);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_ack <= '0;
      cnt_ff  <= 2'h0;
    end else if (cpu_ack.ack) begin
      // Stale request still visible here, so never ack twice in a row
      cpu_ack <= {1'b0, ~cpu_ack.vector};
    end else if (take && cnt_ff == dly) begin
      cpu_ack <= {1'b1, cpu_req.vector};
      cnt_ff  <= 2'h0;
    end else if (take) begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
endmodule

// ### verif/address_break_and_irq_sources_tb_top.sv
/*
  Self-checking bench for abi_top with the core model.
  Assumes zero-wait APB and byte lane 0 registers.
*/
`timescale 1ns/1ps
module address_break_and_irq_sources_tb_top;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, fetch_valid;
  logic        nmi_pin, dtc_start, wake, hw_standby, mask, rerr;
  logic [1:0]  dly;
  logic [2:0]  irq_pin_n;
  logic [3:0]  pstrb;
  logic [11:0] paddr;
  logic [23:0] fetch_addr;
  logic [31:0] pwdata, prdata, peri_req, peri_dtc, rdat;
  int          bad_count, n_checks;
  int          ack_cnt [32];
  logic [11:0] regs [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h024};
  abi_pkg::abi_ack_s cpu_ack;
  abi_pkg::abi_req_s cpu_req;
  abi_top abi_top_inst (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n), .peri_req(peri_req), .peri_dtc(peri_dtc),
    .cpu_ack(cpu_ack), .cpu_req(cpu_req), .dtc_start(dtc_start), .wake(wake),
    .hw_standby(hw_standby)
  );
  abi_cpu_model abi_cpu_model_inst (
    .clock(clock), .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_ack(cpu_ack),
    .mask(mask), .dly(dly)
  );
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    if (cpu_ack.ack === 1'b1) ack_cnt[cpu_ack.vector[4:0]]++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
    end
    if (n == 50) bad_count++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, e);
  endtask
  task automatic fetch(input logic [23:0] a);
    @(posedge clock);
    fetch_valid <= 1'b1;
    fetch_addr  <= a;
    @(posedge clock);
    fetch_valid <= 1'b0;
    fetch_addr  <= ~a;
  endtask
  task automatic wait_vec(input logic [7:0] v);
    int n;
    n = 0;
    while (!(cpu_req.valid === 1'b1 && cpu_req.vector === v) && n < 100) begin
      @(posedge clock);
      n++;
    end
    chk("request vector", {24'h0, cpu_req.vector}, {24'h0, v});
  endtask
  function automatic logic [31:0] exp_rd(input logic [11:0] a, input logic [31:0] d);
    return (a == 12'h000) ? d & 32'h1 : (a == 12'h00c) ? d & 32'hfe :
           (a == 12'h024) ? d : d & 32'hff;
  endfunction
  function automatic logic [31:0] exp_fall(input int c, input int p);
    return (c == 2) ? 32'h0 : 32'h1 << p;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [23:0] ba;
    int          p;
    {psel, penable, pwrite, fetch_valid, hw_standby, paddr, pwdata} = '0;
    {fetch_addr, peri_req, peri_dtc, dly} = '0;
    {sys_rst, nmi_pin, mask} = 3'h7;
    irq_pin_n = 3'h7;
    pstrb = 4'hf;
    d = $urandom(32'ha72f);
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (regs[i]) begin
      rc(regs[i], 32'h0, "reset value");
      d = $urandom;
      apb(1'b1, regs[i], d);
      rc(regs[i], exp_rd(regs[i], d), "readback");
    end
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped error", {31'h0, rerr}, 32'h1);
    // Break: normal mode also ignores the high byte
    for (int m = 0; m < 2; m++) begin
      ba = 24'($urandom) & 24'hfffffe;
      apb(1'b1, 12'h010, 32'(m << 1));
      apb(1'b1, 12'h004, {24'h0, ba[23:16]});
      apb(1'b1, 12'h008, {24'h0, ba[15:8]});
      apb(1'b1, 12'h00c, {24'h0, ba[7:0]});
      apb(1'b1, 12'h000, 32'h1);
      fetch(ba ^ 24'h000100);
      rc(12'h000, 32'h01, "flag on miss");
      fetch(ba ^ {(m == 1) ? 8'h5a : 8'h00, 16'h0001});
      rc(12'h000, 32'h81, "flag on hit");
      apb(1'b1, 12'h000, 32'h0);
      @(posedge clock);
      chk("disabled request", {31'h0, cpu_req.valid}, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      wait_vec(8'h1b);
      mask <= 1'b0;
      repeat (8) @(posedge clock);
      mask <= 1'b1;
      rc(12'h000, 32'h01, "flag after handling");
    end
    chk("break acks", ack_cnt[27], 32'd2);
    // NMI taken while the core is masked
    for (int e = 0; e < 2; e++) begin
      dly <= 2'($urandom);
      apb(1'b1, 12'h010, 32'(e));
      nmi_pin <= 1'b0;
      repeat (10) @(posedge clock);
      nmi_pin <= 1'b1;
      repeat (10) @(posedge clock);
      chk("nmi acks", ack_cnt[7], 32'(e + 1));
    end
    // Flags set with the pins disabled
    for (int c = 0; c < 4; c++) begin
      p = $urandom_range(2, 0);
      apb(1'b1, 12'h014, 32'(c) << (2 * p));
      irq_pin_n[p] <= 1'b0;
      repeat (6) @(posedge clock);
      rc(12'h01c, exp_fall(c, p), "flag after fall");
      irq_pin_n[p] <= 1'b1;
      repeat (6) @(posedge clock);
      apb(1'b1, 12'h01c, 32'h7);
      rc(12'h01c, 32'h1 << p, "flag after rise");
      apb(1'b1, 12'h01c, 32'h0);
      rc(12'h01c, 32'h0, "flag cleared");
    end
    apb(1'b1, 12'h014, 32'h15);
    apb(1'b1, 12'h018, 32'h7);
    for (int q = 0; q < 3; q++) begin
      irq_pin_n[q] <= 1'b0;
      wait_vec(8'(16 + q));
      chk("wake", {31'h0, wake}, 32'h1);
      mask <= 1'b0;
      repeat (6) @(posedge clock);
      mask <= 1'b1;
      irq_pin_n[q] <= 1'b1;
      rc(12'h01c, 32'h0, "edge flag handled");
    end
    // Level 1 pin outranks a lower vector at level 0
    apb(1'b1, 12'h020, 32'h4);
    irq_pin_n[0] <= 1'b0;
    irq_pin_n[2] <= 1'b0;
    repeat (6) @(posedge clock);
    rc(12'h028, 32'h312, "pending level order");
    mask <= 1'b0;
    repeat (16) @(posedge clock);
    mask <= 1'b1;
    irq_pin_n <= 3'h7;
    rc(12'h01c, 32'h0, "level pins handled");
    // Low level: handling cannot clear while the pin is low
    apb(1'b1, 12'h014, 32'h0);
    irq_pin_n[0] <= 1'b0;
    mask <= 1'b0;
    repeat (10) @(posedge clock);
    rc(12'h01c, 32'h1, "level flag held");
    irq_pin_n[0] <= 1'b1;
    repeat (10) @(posedge clock);
    rc(12'h01c, 32'h0, "level flag released");
    repeat (30) begin
      @(posedge clock);
      chk("transfer start", {31'h0, dtc_start}, {31'h0, |(peri_req & peri_dtc)});
      peri_req <= $urandom;
      peri_dtc <= $urandom;
    end
    peri_req <= 32'h0;
    apb(1'b1, 12'h004, 32'hff);
    hw_standby <= 1'b1;
    repeat (2) @(posedge clock);
    hw_standby <= 1'b0;
    rc(12'h004, 32'h0, "standby clears");
    report_and_stop();
  end
endmodule
